//--- hdl/isf_flag.sv
`timescale 1ns/100ps
// sticky flag: set wins over clear so no event is lost
module isf_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : isf_flag

//--- hdl/isf_seq.sv
`timescale 1ns/100ps
// two-step clear: armed by a status read, fired by the following access
module isf_seq (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // steps
  input  wire logic arm,
  input  wire logic trig,
  input  wire logic cancel,
  // result
  output logic      fire
);
  logic armed_q;

  assign fire = armed_q & trig;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (cancel) begin
      armed_q <= 1'b0;
    end else if (arm) begin
      armed_q <= 1'b1;
    end else if (trig) begin
      armed_q <= 1'b0;
    end
  end
endmodule : isf_seq

//--- hdl/isf_top.sv
`timescale 1ns/100ps
module isf_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [15:0] reg_rdata,
  // events from the bit engine
  input  wire logic       ev_start_gen,
  input  wire logic       ev_start_cond,
  input  wire logic       ev_stop_cond,
  input  wire logic       ev_addr_acked,
  input  wire logic       ev_addr_match,
  input  wire logic       ev_hdr10_sent,
  input  wire logic       ev_byte_sent,
  input  wire logic       ev_byte_rcvd,
  input  wire logic [7:0] rx_byte,
  input  wire logic       ev_crc_bad,
  input  wire logic       ev_ack_missing,
  input  wire logic       ev_arb_lost,
  input  wire logic       ev_misplaced,
  input  wire logic       last_acked,
  input  wire logic       role_controller,
  input  wire logic       role_tx,
  // to the bit engine
  output logic      [7:0] tx_byte,
  output logic            crc_nack,
  output logic            drop_byte,
  output logic            resend_byte,
  output logic            unit_on,
  output logic            no_clock_hold,
  output logic            ack_enable,
  // interrupts
  output logic            err_irq,
  output logic            evt_irq
);
  // ****************************************
  // register decode
  // ****************************************
  logic        wr_ctl1, wr_ctl2, wr_buf, wr_st1;
  logic        rd_buf, rd_st1, rd_st2;
  logic [15:0] ctl1_q, ctl2_q;
  logic [7:0]  buf_q;
  logic [15:0] st1, st2;
  logic        on;

  assign wr_ctl1 = reg_wr & (reg_addr == isf_pkg::OFS_CONTROL_ONE);
  assign wr_ctl2 = reg_wr & (reg_addr == isf_pkg::OFS_CONTROL_TWO);
  assign wr_buf  = reg_wr & (reg_addr == isf_pkg::OFS_BYTE_BUFFER);
  assign wr_st1  = reg_wr & (reg_addr == isf_pkg::OFS_STATUS_ONE);
  assign rd_buf  = reg_rd & (reg_addr == isf_pkg::OFS_BYTE_BUFFER);
  assign rd_st1  = reg_rd & (reg_addr == isf_pkg::OFS_STATUS_ONE);
  assign rd_st2  = reg_rd & (reg_addr == isf_pkg::OFS_STATUS_TWO);
  assign on      = ctl1_q[isf_pkg::B_UNIT_ON];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl1_q <= isf_pkg::RST_REG;
    end else if (wr_ctl1) begin
      ctl1_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl2_q <= isf_pkg::RST_REG;
    end else if (wr_ctl2) begin
      ctl2_q <= reg_wdata;
    end
  end

  // ****************************************
  // flag set and clear terms
  // ****************************************
  logic f_crc, f_ovr, f_af, f_arb, f_bus, f_txe, f_rxf;
  logic f_stop, f_ten, f_btf, f_addr, f_sb;
  logic hold_off, rx_over, tx_under, rx_take, tx_take, cond;
  logic fire_stop, fire_ten, fire_btf, fire_addr, fire_sb;
  logic [11:0] set_v, clr_v, q_v;

  assign hold_off = ctl1_q[isf_pkg::B_NO_CLOCK_HOLD];
  assign cond     = ev_start_cond | ev_stop_cond;
  assign tx_take  = on & ev_byte_sent & role_tx;
  assign rx_over  = on & ev_byte_rcvd & f_rxf & hold_off;
  assign tx_under = tx_take & f_txe & hold_off;
  // while holding the clock the engine waits, so an unread byte is never replaced
  assign rx_take  = on & ev_byte_rcvd & ~f_rxf;

  // software clears of RW0 bits: a 0 clears, a 1 leaves the bit alone
  // a vector, not a function: a continuous assign would not see the strobe
  logic [15:0] wr_zero;
  assign wr_zero = {16{wr_st1}} & ~reg_wdata;

  assign set_v[0]  = on & ev_crc_bad;
  assign clr_v[0]  = ~on | wr_zero[isf_pkg::B_CRC_MISMATCH];
  assign set_v[1]  = rx_over | tx_under;
  assign clr_v[1]  = ~on | wr_zero[isf_pkg::B_OVERRUN];
  assign set_v[2]  = on & ev_ack_missing;
  assign clr_v[2]  = ~on | wr_zero[isf_pkg::B_ACK_FAIL];
  assign set_v[3]  = on & ev_arb_lost;
  assign clr_v[3]  = ~on | wr_zero[isf_pkg::B_LOST_ARB];
  assign set_v[4]  = on & ev_misplaced;
  assign clr_v[4]  = ~on | wr_zero[isf_pkg::B_BUS_FAULT];
  assign set_v[5]  = tx_take & ~wr_buf;
  assign clr_v[5]  = ~on | wr_buf | cond;
  assign set_v[6]  = rx_take;
  assign clr_v[6]  = ~on | rd_buf | wr_buf;
  assign set_v[7]  = on & ev_stop_cond & ~role_controller & last_acked
                     & ctl1_q[isf_pkg::B_ACK_ENABLE];
  assign clr_v[7]  = ~on | fire_stop;
  assign set_v[8]  = on & role_controller & ev_hdr10_sent;
  assign clr_v[8]  = ~on | fire_ten;
  assign set_v[9]  = on & ~hold_off & ((tx_take & f_txe & ~wr_buf)
                     | (ev_byte_rcvd & f_rxf));
  assign clr_v[9]  = ~on | fire_btf | (cond & role_tx);
  assign set_v[10] = on & (role_controller ? ev_addr_acked : ev_addr_match);
  assign clr_v[10] = ~on | fire_addr | wr_zero[isf_pkg::B_ADDR_DONE];
  assign set_v[11] = on & ev_start_gen;
  assign clr_v[11] = ~on | fire_sb;

  // ****************************************
  // sticky flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_flag
      isf_flag u_flag (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set     (set_v[gi]),
        .clr     (clr_v[gi]),
        .q       (q_v[gi])
      );
    end
  endgenerate

  assign f_crc  = q_v[0];
  assign f_ovr  = q_v[1];
  assign f_af   = q_v[2];
  assign f_arb  = q_v[3];
  assign f_bus  = q_v[4];
  assign f_txe  = q_v[5];
  assign f_rxf  = q_v[6];
  assign f_stop = q_v[7];
  assign f_ten  = q_v[8];
  assign f_btf  = q_v[9];
  assign f_addr = q_v[10];
  assign f_sb   = q_v[11];

  // ****************************************
  // two-step clear sequences
  // ****************************************
  isf_seq u_seq_stop (
    .clk (clk), .sys_rst (sys_rst), .arm (rd_st1), .trig (wr_ctl1),
    .cancel (~on), .fire (fire_stop)
  );
  isf_seq u_seq_ten (
    .clk (clk), .sys_rst (sys_rst), .arm (rd_st1), .trig (wr_buf),
    .cancel (~on), .fire (fire_ten)
  );
  isf_seq u_seq_btf (
    .clk (clk), .sys_rst (sys_rst), .arm (rd_st1), .trig (wr_buf | rd_buf),
    .cancel (~on), .fire (fire_btf)
  );
  isf_seq u_seq_addr (
    .clk (clk), .sys_rst (sys_rst), .arm (rd_st1), .trig (rd_st2),
    .cancel (~on), .fire (fire_addr)
  );
  isf_seq u_seq_sb (
    .clk (clk), .sys_rst (sys_rst), .arm (rd_st1), .trig (wr_buf),
    .cancel (~on), .fire (fire_sb)
  );

  // ****************************************
  // byte buffer
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= isf_pkg::RST_BYTE;
    end else if (wr_buf) begin
      buf_q <= reg_wdata[7:0];
    end else if (rx_take) begin
      buf_q <= rx_byte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_nack    <= 1'b0;
      drop_byte   <= 1'b0;
      resend_byte <= 1'b0;
    end else begin
      crc_nack    <= set_v[0];
      drop_byte   <= rx_over;
      resend_byte <= tx_under;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_byte       <= isf_pkg::RST_BYTE;
      unit_on       <= 1'b0;
      no_clock_hold <= 1'b0;
      ack_enable    <= 1'b0;
    end else begin
      tx_byte       <= wr_buf ? reg_wdata[7:0] : buf_q;
      unit_on       <= wr_ctl1 ? reg_wdata[isf_pkg::B_UNIT_ON] : on;
      no_clock_hold <= wr_ctl1 ? reg_wdata[isf_pkg::B_NO_CLOCK_HOLD] : hold_off;
      ack_enable    <= wr_ctl1 ? reg_wdata[isf_pkg::B_ACK_ENABLE]
                               : ctl1_q[isf_pkg::B_ACK_ENABLE];
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic err_any, evt_any;
  assign err_any = f_bus | f_arb | f_af | f_ovr | f_crc;
  assign evt_any = f_sb | f_addr | f_ten | f_stop | f_btf
                   | (ctl2_q[isf_pkg::B_BUF_IRQ_EN] & (f_txe | f_rxf));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_irq <= 1'b0;
      evt_irq <= 1'b0;
    end else begin
      err_irq <= ctl2_q[isf_pkg::B_ERR_IRQ_EN] & err_any;
      evt_irq <= ctl2_q[isf_pkg::B_EVT_IRQ_EN] & evt_any;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    st1 = 16'h0000;
    st1[isf_pkg::B_CRC_MISMATCH] = f_crc;
    st1[isf_pkg::B_OVERRUN]      = f_ovr;
    st1[isf_pkg::B_ACK_FAIL]     = f_af;
    st1[isf_pkg::B_LOST_ARB]     = f_arb;
    st1[isf_pkg::B_BUS_FAULT]    = f_bus;
    st1[isf_pkg::B_TX_EMPTY]     = f_txe;
    st1[isf_pkg::B_RX_FULL]      = f_rxf;
    st1[isf_pkg::B_STOP_DET]     = f_stop;
    st1[isf_pkg::B_TEN_HDR]      = f_ten;
    st1[isf_pkg::B_BYTE_DONE]    = f_btf;
    st1[isf_pkg::B_ADDR_DONE]    = f_addr;
    st1[isf_pkg::B_START_SENT]   = f_sb;
    st2 = 16'h0000;
    st2[isf_pkg::B_ROLE_CTRL]    = role_controller & on;
    st2[isf_pkg::B_ROLE_TX]      = role_tx & on;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= isf_pkg::RST_REG;
    end else if (reg_rd) begin
      case (reg_addr)
        isf_pkg::OFS_CONTROL_ONE: reg_rdata <= ctl1_q;
        isf_pkg::OFS_CONTROL_TWO: reg_rdata <= ctl2_q;
        isf_pkg::OFS_BYTE_BUFFER: reg_rdata <= {8'h00, buf_q};
        isf_pkg::OFS_STATUS_ONE:  reg_rdata <= st1;
        isf_pkg::OFS_STATUS_TWO:  reg_rdata <= st2;
        default:                  reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_crc_nack_set:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && ev_crc_bad |=> crc_nack && f_crc)
    else $error("checksum mismatch not flagged or not refused");

  a_crc_clear_zero:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && !ev_crc_bad && wr_st1 && !reg_wdata[12] |=> !f_crc)
    else $error("checksum flag survived write of zero");

  a_overrun_drop:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && hold_off && f_rxf && ev_byte_rcvd && !wr_buf |=> f_ovr && drop_byte && $stable(buf_q))
    else $error("overrun byte not dropped");

  a_underrun_resend:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && hold_off && f_txe && ev_byte_sent && role_tx |=> f_ovr && resend_byte)
    else $error("underrun not flagged");

  a_write_one_keeps:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && f_af && wr_st1 && reg_wdata[10] |=> f_af)
    else $error("write of one cleared ack failure");

  a_disable_clears:
  assert property (@(posedge clk) disable iff (sys_rst)
    !on ##1 !on |-> st1 == 16'h0000)
    else $error("flags remain while disabled");

  a_stop_two_step:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && f_stop && rd_st1 ##1 wr_ctl1 && !set_v[7] && !reg_rd |=> !f_stop)
    else $error("stop flag not cleared by read then control write");

  a_start_two_step:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && rd_st1 ##1 wr_buf && !ev_start_gen |=> !f_sb)
    else $error("start flag not cleared by read then buffer write");

  a_err_irq_follows:
  assert property (@(posedge clk) disable iff (sys_rst)
    ##1 err_irq == $past(ctl2_q[8] && (f_bus || f_arb || f_af || f_ovr || f_crc)))
    else $error("error interrupt does not follow flags");

  a_rx_full_set:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && ev_byte_rcvd && !f_rxf && !wr_buf |=> f_rxf && buf_q == $past(rx_byte))
    else $error("received byte not stored");

  a_byte_done_rx:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && !hold_off && ev_byte_rcvd && f_rxf |=> f_btf)
    else $error("byte done not set on unread receive");

  a_tx_empty_clear:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && wr_buf |=> !f_txe)
    else $error("buffer write left tx empty set");

  a_addr_two_step:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && rd_st1 ##1 rd_st2 && !set_v[10] |=> !f_addr)
    else $error("address flag not cleared by two status reads");

  a_ten_hdr_set:
  assert property (@(posedge clk) disable iff (sys_rst)
    on && role_controller && ev_hdr10_sent |=> f_ten)
    else $error("ten-bit header flag not set");
endmodule : isf_top

//--- inc/isf_pkg.sv
// Summary of operation
// - received checksum mismatch sets bit 12 and answers that byte with not-acknowledge
// - checksum mismatch clears on software write of 0 or interface disable
// - no clock hold: byte arriving before buffer read is dropped, overrun bit 11 set
// - no clock hold: buffer not refilled when sending, old byte resent, overrun set
// - missing acknowledge sets bit 10; cleared by write 0 or disable
// - lost arbitration sets bit 9; cleared by write 0 or disable
// - misplaced start or stop sets bit 8; cleared by write 0 or disable
// - bit 7 high while buffer empty; cleared by buffer write, start/stop, disable
// - bit 6 high while buffer holds byte; cleared by buffer access or disable
// - target role: stop after acknowledge with acknowledging enabled sets bit 4
// - stop flag clears on status read then control write, or disable
// - controller sends ten-bit header: bit 3; status read then buffer write clears
// - clock hold on: bit 2 when sent without refill or received while unread
// - byte done clears on status read then buffer access, start/stop sending, disable
// - bit 1 set after address acknowledge (controller) or address match (target)
// - address done clears on status one read then status two read, write 0, or disable
// - bit 0 set on generated start; status read then buffer write clears
// - error interrupt while enabled and any error flag is set
// - event interrupt on event flags, buffer flags only with buffer enable
package isf_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_BYTE_BUFFER = 8'h10;
  localparam logic [7:0] OFS_STATUS_ONE  = 8'h14;
  localparam logic [7:0] OFS_STATUS_TWO  = 8'h18;

  // ****************************************
  // status_one field positions
  // ****************************************
  localparam int B_CRC_MISMATCH = 12;
  localparam int B_OVERRUN      = 11;
  localparam int B_ACK_FAIL     = 10;
  localparam int B_LOST_ARB     = 9;
  localparam int B_BUS_FAULT    = 8;
  localparam int B_TX_EMPTY     = 7;
  localparam int B_RX_FULL      = 6;
  localparam int B_STOP_DET     = 4;
  localparam int B_TEN_HDR      = 3;
  localparam int B_BYTE_DONE    = 2;
  localparam int B_ADDR_DONE    = 1;
  localparam int B_START_SENT   = 0;

  // ****************************************
  // control and status two field positions
  // ****************************************
  localparam int B_UNIT_ON       = 0;
  localparam int B_NO_CLOCK_HOLD = 7;
  localparam int B_ACK_ENABLE    = 10;
  localparam int B_ERR_IRQ_EN    = 8;
  localparam int B_EVT_IRQ_EN    = 9;
  localparam int B_BUF_IRQ_EN    = 10;
  localparam int B_ROLE_CTRL     = 0;
  localparam int B_ROLE_TX       = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_REG  = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
endpackage : isf_pkg

//--- verif/isf_engine_model.sv
`timescale 1ns/100ps
// ****************************************
// stand-in for the bit engine and bus
// ****************************************
module isf_engine_model (
  // clock
  input  wire logic clk,
  // event pulses and received data
  output logic [11:0] ev,
  output logic [7:0]  rx_byte,
  // levels
  output logic        last_acked,
  output logic        role_controller,
  output logic        role_tx
);
  initial begin
    ev              = 12'h000;
    rx_byte         = 8'h00;
    last_acked      = 1'b0;
    role_controller = 1'b0;
    role_tx         = 1'b0;
  end

  // one-cycle pulse; data valid only beside the receive pulse
  task automatic pulse(input int code, input logic [7:0] data);
    @(posedge clk);
    ev      <= 12'h001 << code;
    rx_byte <= data;
    @(posedge clk);
    ev      <= 12'h000;
    rx_byte <= ~data;
  endtask : pulse

  task automatic levels(input logic ctrl, input logic tx, input logic acked);
    @(posedge clk);
    role_controller <= ctrl;
    role_tx         <= tx;
    last_acked      <= acked;
  endtask : levels
endmodule : isf_engine_model

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int E_SG = 0, E_SC = 1, E_SP = 2, E_AA = 3, E_AM = 4, E_H10 = 5;
  localparam int E_BS = 6, E_BR = 7, E_CRC = 8, E_AF = 9, E_ARB = 10, E_MIS = 11;
  localparam logic [15:0] S_CRC = 16'h0001 << isf_pkg::B_CRC_MISMATCH;
  localparam logic [15:0] S_OVR = 16'h0001 << isf_pkg::B_OVERRUN;
  localparam logic [15:0] S_AF  = 16'h0001 << isf_pkg::B_ACK_FAIL;
  localparam logic [15:0] S_ARB = 16'h0001 << isf_pkg::B_LOST_ARB;
  localparam logic [15:0] S_BUS = 16'h0001 << isf_pkg::B_BUS_FAULT;
  localparam logic [15:0] S_TXE = 16'h0001 << isf_pkg::B_TX_EMPTY;
  localparam logic [15:0] S_RXF = 16'h0001 << isf_pkg::B_RX_FULL;
  localparam logic [15:0] S_STP = 16'h0001 << isf_pkg::B_STOP_DET;
  localparam logic [15:0] S_H10 = 16'h0001 << isf_pkg::B_TEN_HDR;
  localparam logic [15:0] S_BTF = 16'h0001 << isf_pkg::B_BYTE_DONE;
  localparam logic [15:0] S_ADR = 16'h0001 << isf_pkg::B_ADDR_DONE;
  localparam logic [15:0] S_SB  = 16'h0001 << isf_pkg::B_START_SENT;
  localparam logic [7:0]  A_C1 = isf_pkg::OFS_CONTROL_ONE, A_C2 = isf_pkg::OFS_CONTROL_TWO;
  localparam logic [7:0]  A_BUF = isf_pkg::OFS_BYTE_BUFFER, A_S1 = isf_pkg::OFS_STATUS_ONE;

  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, tx_byte, rx_byte, seed = 8'h4f;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [11:0] ev;
  logic last_acked, role_controller, role_tx, crc_nack, drop_byte, resend_byte;
  logic unit_on, no_clock_hold, ack_enable, err_irq, evt_irq;
  int fail_count = 0, compares = 0;
  logic [15:0] codes [4] = '{E_CRC, E_AF, E_ARB, E_MIS};
  logic [15:0] masks [4] = '{S_CRC, S_AF, S_ARB, S_BUS};

  initial begin
    forever #20 clk = ~clk;
  end

  isf_engine_model u_eng (.clk(clk), .ev(ev), .rx_byte(rx_byte), .last_acked(last_acked),
    .role_controller(role_controller), .role_tx(role_tx));

  isf_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_start_gen(ev[E_SG]),
    .ev_start_cond(ev[E_SC]), .ev_stop_cond(ev[E_SP]), .ev_addr_acked(ev[E_AA]),
    .ev_addr_match(ev[E_AM]), .ev_hdr10_sent(ev[E_H10]), .ev_byte_sent(ev[E_BS]),
    .ev_byte_rcvd(ev[E_BR]), .rx_byte(rx_byte), .ev_crc_bad(ev[E_CRC]),
    .ev_ack_missing(ev[E_AF]), .ev_arb_lost(ev[E_ARB]), .ev_misplaced(ev[E_MIS]),
    .last_acked(last_acked), .role_controller(role_controller), .role_tx(role_tx),
    .tx_byte(tx_byte), .crc_nack(crc_nack), .drop_byte(drop_byte),
    .resend_byte(resend_byte), .unit_on(unit_on), .no_clock_hold(no_clock_hold),
    .ack_enable(ack_enable), .err_irq(err_irq), .evt_irq(evt_irq));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // off then on: clears every flag and any half-done two-step clear
  task automatic reenable(input logic [15:0] ctl);
    wr(A_C1, 16'h0000);
    wr(A_C1, ctl);
  endtask : reenable

  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    logic [15:0] v;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(A_S1, v);
    check(v, 16'h0000, "status after reset");
    u_eng.pulse(E_AF, 8'h00);
    reenable(16'h0001);
    #1 check({15'h0, unit_on}, 16'h0001, "unit on");
    rd(A_S1, v);
    check(v, 16'h0000, "event while disabled");
    rd(8'h20, v);
    check(v, 16'h0000, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      u_eng.pulse(int'(codes[i]), 8'h00);
      if (codes[i] == E_CRC) begin
        #1 check({15'h0, crc_nack}, 16'h0001, "nack on checksum");
      end
      rd(A_S1, v);
      check(v, masks[i], "error flag set");
      wr(A_S1, 16'hffff);
      rd(A_S1, v);
      check(v, masks[i], "write one keeps");
      wr(A_S1, 16'h0000);
      rd(A_S1, v);
      check(v, 16'h0000, "write zero clears");
    end
    // overrun and underrun with clock holding off
    reenable(16'h0081);
    #1 check({15'h0, no_clock_hold}, 16'h0001, "no clock hold");
    u_eng.pulse(E_BR, 8'h5a);
    u_eng.pulse(E_BR, 8'ha5);
    #1 check({15'h0, drop_byte}, 16'h0001, "drop pulse");
    rd(A_S1, v);
    check(v, S_RXF | S_OVR, "overrun");
    rd(A_BUF, v);
    check(v, 16'h005a, "first byte kept");
    rd(A_S1, v);
    check(v, S_OVR, "rx full cleared by read");
    reenable(16'h0081);
    u_eng.levels(1'b0, 1'b1, 1'b0);
    wr(A_BUF, 16'h00c3);
    u_eng.pulse(E_BS, 8'h00);
    rd(A_S1, v);
    check(v, S_TXE, "tx empty");
    u_eng.pulse(E_BS, 8'h00);
    #1 check({15'h0, resend_byte}, 16'h0001, "resend pulse");
    rd(A_S1, v);
    check(v, S_TXE | S_OVR, "underrun");
    wr(A_BUF, 16'h0011);
    wr(A_S1, 16'h0000);
    rd(A_S1, v);
    check(v, 16'h0000, "buffer write clears empty");
    u_eng.pulse(E_BS, 8'h00);
    u_eng.pulse(E_SC, 8'h00);
    rd(A_S1, v);
    check(v, 16'h0000, "start clears empty");
    // random receive and send with clock holding on
    reenable(16'h0001);
    wr(A_BUF, 16'h0077);
    u_eng.pulse(E_BS, 8'h00);
    u_eng.pulse(E_BS, 8'h00);
    rd(A_S1, v);
    check(v, S_TXE | S_BTF, "byte done on send");
    u_eng.pulse(E_SP, 8'h00);
    rd(A_S1, v);
    check(v, 16'h0000, "stop clears empty and byte done");
    u_eng.levels(1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr_next(seed);
      wr(A_BUF, {8'h00, seed});
      @(posedge clk);
      #1 check({8'h00, tx_byte}, {8'h00, seed}, "tx copy");
      seed = lfsr_next(seed);
      u_eng.pulse(E_BR, seed);
      // second byte while the first is unread: engine stalls, byte not stored
      u_eng.pulse(E_BR, ~seed);
      rd(A_S1, v);
      check(v, S_RXF | S_BTF, "byte done on receive");
      rd(A_BUF, v);
      check(v, {8'h00, seed}, "received byte");
      rd(A_S1, v);
      check(v, 16'h0000, "byte done cleared");
    end
    // stop detection as target
    u_eng.levels(1'b0, 1'b0, 1'b1);
    reenable(16'h0401);
    #1 check({15'h0, ack_enable}, 16'h0001, "ack enable");
    u_eng.pulse(E_SP, 8'h00);
    wr(A_C1, 16'h0401);
    rd(A_S1, v);
    check(v, S_STP, "stop kept without status read");
    wr(A_C1, 16'h0401);
    rd(A_BUF, v);
    rd(A_S1, v);
    check(v, 16'h0000, "stop cleared");
    u_eng.pulse(E_AM, 8'h00);
    rd(A_S1, v);
    check(v, S_ADR, "address match as target");
    rd(isf_pkg::OFS_STATUS_TWO, v);
    check(v, 16'h0000, "role reads target");
    rd(A_S1, v);
    check(v, 16'h0000, "match cleared");
    // controller start, ten-bit header, address
    u_eng.levels(1'b1, 1'b0, 1'b0);
    reenable(16'h0001);
    u_eng.pulse(E_SG, 8'h00);
    u_eng.pulse(E_H10, 8'h00);
    wr(A_BUF, 16'h00f0);
    rd(A_S1, v);
    check(v, S_SB | S_H10, "start and header");
    wr(A_BUF, 16'h0033);
    rd(A_S1, v);
    check(v, 16'h0000, "start and header cleared");
    u_eng.pulse(E_AA, 8'h00);
    rd(A_S1, v);
    check(v, S_ADR, "address done");
    rd(isf_pkg::OFS_STATUS_TWO, v);
    check(v, 16'h0001, "role reads controller");
    rd(A_S1, v);
    check(v, 16'h0000, "address done cleared");
    // interrupts
    wr(A_C2, 16'h0100);
    u_eng.pulse(E_ARB, 8'h00);
    @(posedge clk);
    #1 check({15'h0, err_irq}, 16'h0001, "error irq");
    wr(A_C2, 16'h0200);
    u_eng.pulse(E_SG, 8'h00);
    @(posedge clk);
    #1 check({14'h0, err_irq, evt_irq}, 16'h0001, "event irq");
    u_eng.pulse(E_CRC, 8'h00);
    wr(A_C1, 16'h0000);
    rd(A_S1, v);
    check(v, 16'h0000, "disable clears all");
    complete_run();
  end
endmodule : tb
